/* File: inc/arf_pkg.sv */
// Package with register offsets, field layouts, thresholds and carriers for the register bank.
package arf_pkg;

  // ********************
  // Register word offsets
  // ********************
  localparam logic [7:0] OFS_FEATURE_SETTINGS = 8'h01;
  localparam logic [7:0] OFS_DISPLAY_PARAMETERS = 8'h02;
  localparam logic [7:0] OFS_UNIT_SELECTION = 8'h03;
  localparam logic [7:0] OFS_FIRST_ALARM_SETPOINT = 8'h06;
  localparam logic [7:0] OFS_SECOND_ALARM_SETPOINT = 8'h07;
  localparam logic [7:0] OFS_ALARM_ERROR_CONFIG = 8'h16;
  localparam logic [7:0] OFS_SET_HOURS = 8'h41;
  localparam logic [7:0] OFS_SET_YEAR = 8'h45;
  localparam logic [7:0] OFS_STATUS_ERROR_FLAGS = 8'h4D;
  localparam logic [7:0] OFS_CLOCK_HOUR_MIN = 8'h4E;
  localparam logic [7:0] OFS_CLOCK_SEC_DAY = 8'h4F;
  localparam logic [7:0] OFS_CLOCK_MONTH_YEAR = 8'h50;

  // ********************
  // Field masks and reset values
  // ********************
  localparam logic [15:0] SETTINGS_MASK = 16'h003F;
  localparam logic [15:0] UNITS_MASK = 16'h383F;
  localparam logic [15:0] ALARM_CFG_MASK = 16'h001F;
  localparam logic [15:0] STATUS_MASK = 16'h07FF;
  localparam logic [15:0] SETTINGS_RESET = 16'h0000;
  localparam logic [15:0] DISPLAY_RESET = 16'h3232;
  localparam logic [15:0] UNITS_RESET = 16'h0000;
  localparam logic [15:0] ALARM_CFG_RESET = 16'h0000;
  localparam logic [15:0] SETPOINT_RESET = 16'h4E20;
  localparam logic [7:0] PERCENT_MAX = 8'h64;
  localparam logic [7:0] PERCENT_STEP = 8'h0A;

  // ********************
  // Value encodings
  // ********************
  localparam int F_OFFSET = 20000;
  localparam int G_OFFSET = 20000;
  localparam int K_OFFSET = 32767;
  localparam int FG_RAW_MAX = 40000;
  localparam logic [1:0] ALARM_OFF = 2'h0;
  localparam logic [1:0] ALARM_LOW = 2'h1;
  localparam logic [1:0] ALARM_HIGH = 2'h2;
  localparam logic [2:0] EXT_NONE = 3'h0;
  localparam logic [2:0] EXT_DEWPOINT = 3'h1;
  localparam logic [2:0] EXT_TEMPERATURE = 3'h2;
  localparam logic [2:0] EXT_PRESSURE = 3'h3;
  localparam logic [2:0] EXT_OTHER = 3'h4;

  // ********************
  // Detection thresholds
  // ********************
  localparam int LOOP_MIN_UA = 3600;
  localparam int LOOP_MAX_UA = 21000;
  localparam int CELL_WINDOW_HUNDREDTHS = 15;
  localparam int CELL_MIN_TENTHS = -500;
  localparam int CELL_MAX_TENTHS = 800;
  localparam int PRESS_MIN_MBAR = 700;
  localparam int PRESS_MAX_MBAR = 1300;
  localparam logic [12:0] O2_CODE_LOW = 13'h0001;
  localparam logic [12:0] O2_CODE_HIGH = 13'h1FFF;

  // ********************
  // External sensor scaling limits in the one-decimal raw format
  // ********************
  localparam logic [15:0] DEW_C_LO = 16'h4A38;
  localparam logic [15:0] DEW_C_HI = 16'h4EE8;
  localparam logic [15:0] DEW_F_LO = 16'h4858;
  localparam logic [15:0] DEW_F_HI = 16'h50C8;
  localparam logic [15:0] DEW_K_LO = 16'h54E2;
  localparam logic [15:0] DEW_K_HI = 16'h5992;
  localparam logic [15:0] TMP_C_LO = 16'h4C2C;
  localparam logic [15:0] TMP_C_HI = 16'h5208;
  localparam logic [15:0] TMP_F_LO = 16'h4BDC;
  localparam logic [15:0] TMP_F_HI = 16'h5668;
  localparam logic [15:0] TMP_K_LO = 16'h56D6;
  localparam logic [15:0] TMP_K_HI = 16'h5CB2;
  localparam logic [15:0] PRS_ZERO = 16'h4E20;
  localparam logic [15:0] PRS_PSIA_HI = 16'h4FD9;
  localparam logic [15:0] PRS_BAR_HI = 16'h4E3E;
  localparam logic [15:0] PRS_KPA_HI = 16'h5A00;

  // ********************
  // Timing
  // ********************
  localparam int CLOCK_HZ = 50000000;
  localparam int TICK_MS = 1;
  localparam int TICK_CYCLES = CLOCK_HZ / 1000 * TICK_MS;
  localparam int STABLE_MINUTES = 15;
  localparam int STABLE_TICKS = STABLE_MINUTES * 60000 / TICK_MS;
  localparam int FLASH_MS = 500;
  localparam int FLASH_TICKS = FLASH_MS / TICK_MS;

  // ********************
  // Carriers
  // ********************
  typedef struct packed {
    logic out_of_range;
    logic [15:0] o2_raw;
    logic [15:0] comp_loop_ua;
    logic [15:0] ext_loop_ua;
    logic [15:0] cell_temp_raw;
    logic [15:0] cell_setpoint_c;
    logic [15:0] pressure_mbar;
    logic [12:0] o2_code;
    logic [15:0] board_temp_raw;
  } arf_meas_s;

  typedef struct packed {
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] day;
    logic [7:0] month;
    logic [7:0] year;
  } arf_rtc_s;

  typedef struct packed {
    logic red_steady;
    logic red_flash;
    logic yellow1;
    logic yellow2;
    logic error_level_high;
  } arf_ind_s;

endpackage

/* File: hw/arf_register_bank.sv */
// Register bank with status flags, indicator priorities and clock packing for the analyzer.
//
// Operation
// - Settings bits 0-5 drive six feature enables.
// - Display word: brightness high, contrast low byte.
// - Units: temperature bits 1:0, pressure bits 3:2.
// - Units bit 4 calibration type, bit 5 date.
// - Units bits 13:11 pick external sensor quantity.
// - Unsigned registers hold raw 0 to 65535.
// - One-decimal format: raw minus 20000, over ten.
// - Two-decimal format: raw minus 20000, over hundred.
// - Whole-number format: raw minus 32767.
// - Clock reads pack two fields, one per byte.
// - Clock writes use only the low byte.
// - Temperature sensor scaling limits per unit.
// - Pressure sensor scaling limits per unit.
// - Dew point sensor scaling limits per unit.
// - Status word read-only, writes ignored.
// - Status bits 0-3: display, range, alarms.
// - Loop current faults flash red, priority two.
// - Cell temperature flag until stable for 15 minutes.
// - Cell temperature sensor fault outside -50..80.
// - Pressure sensor fault outside 700..1300 mbar.
// - Oxygen code extremes and board overtemperature flag.
// - Alarm config codes two alarms' types.
// - Alarm config bit 4 selects error level.
module arf_register_bank #(
  parameter int TICK_CYCLES = arf_pkg::TICK_CYCLES,
  parameter int STABLE_TICKS = arf_pkg::STABLE_TICKS,
  parameter int FLASH_TICKS = arf_pkg::FLASH_TICKS
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Register access port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  // Measurements and real-time clock
  input wire arf_pkg::arf_meas_s MEAS,
  input wire arf_pkg::arf_rtc_s RTC,
  // Clock setting
  output logic RTC_SET,
  output logic [2:0] RTC_SET_FIELD,
  output logic [7:0] RTC_SET_VALUE,
  // Feature enables, display, units and external scaling
  output logic [5:0] FEATURE_EN,
  output logic [7:0] BRIGHTNESS,
  output logic [7:0] CONTRAST,
  output logic [1:0] TEMP_UNIT,
  output logic [1:0] PRESS_UNIT,
  output logic TWO_GAS_CAL,
  output logic US_DATE,
  output logic [2:0] EXT_QUANTITY,
  output logic [15:0] EXT_SCALE_ZERO,
  output logic [15:0] EXT_SCALE_SPAN,
  // Status and indicators
  output logic [15:0] STATUS,
  output arf_pkg::arf_ind_s INDICATORS
);

  // ********************
  // Registers
  // ********************
  logic [15:0] settings_r;
  logic [15:0] display_r;
  logic [15:0] units_r;
  logic [15:0] alarm_cfg_r;
  logic [15:0] setpoint1_r;
  logic [15:0] setpoint2_r;
  logic [15:0] status_r;
  logic [15:0] status_nxt;

  // ********************
  // Address decode
  // ********************
  wire logic wr_settings = REG_WR && REG_ADDR == arf_pkg::OFS_FEATURE_SETTINGS;
  wire logic wr_display = REG_WR && REG_ADDR == arf_pkg::OFS_DISPLAY_PARAMETERS;
  wire logic wr_units = REG_WR && REG_ADDR == arf_pkg::OFS_UNIT_SELECTION;
  wire logic wr_alarm_cfg = REG_WR && REG_ADDR == arf_pkg::OFS_ALARM_ERROR_CONFIG;
  wire logic wr_sp1 = REG_WR && REG_ADDR == arf_pkg::OFS_FIRST_ALARM_SETPOINT;
  wire logic wr_sp2 = REG_WR && REG_ADDR == arf_pkg::OFS_SECOND_ALARM_SETPOINT;
  wire logic wr_clock = REG_WR && REG_ADDR >= arf_pkg::OFS_SET_HOURS
    && REG_ADDR <= arf_pkg::OFS_SET_YEAR;
  wire logic [7:0] clock_index = REG_ADDR - arf_pkg::OFS_SET_HOURS;

  // Display percentages are accepted only on the documented 10 % grid.
  wire logic bright_ok = REG_WDATA[15:8] <= arf_pkg::PERCENT_MAX
    && (REG_WDATA[15:8] % arf_pkg::PERCENT_STEP) == 8'h00;
  wire logic contrast_ok = REG_WDATA[7:0] <= arf_pkg::PERCENT_MAX
    && (REG_WDATA[7:0] % arf_pkg::PERCENT_STEP) == 8'h00;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      settings_r <= arf_pkg::SETTINGS_RESET;
      display_r <= arf_pkg::DISPLAY_RESET;
      units_r <= arf_pkg::UNITS_RESET;
      alarm_cfg_r <= arf_pkg::ALARM_CFG_RESET;
      setpoint1_r <= arf_pkg::SETPOINT_RESET;
      setpoint2_r <= arf_pkg::SETPOINT_RESET;
    end else begin
      if (wr_settings) begin
        settings_r <= REG_WDATA & arf_pkg::SETTINGS_MASK;
      end
      if (wr_display && bright_ok) begin
        display_r[15:8] <= REG_WDATA[15:8];
      end
      if (wr_display && contrast_ok) begin
        display_r[7:0] <= REG_WDATA[7:0];
      end
      if (wr_units) begin
        units_r <= REG_WDATA & arf_pkg::UNITS_MASK;
      end
      if (wr_alarm_cfg) begin
        alarm_cfg_r <= REG_WDATA & arf_pkg::ALARM_CFG_MASK;
      end
      if (wr_sp1) begin
        setpoint1_r <= REG_WDATA;
      end
      if (wr_sp2) begin
        setpoint2_r <= REG_WDATA;
      end
    end
  end

  // ********************
  // Clock setting
  // ********************
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RTC_SET <= 1'b0;
      RTC_SET_FIELD <= 3'h0;
      RTC_SET_VALUE <= 8'h00;
    end else begin
      RTC_SET <= wr_clock;
      if (wr_clock) begin
        RTC_SET_FIELD <= clock_index[2:0];
        RTC_SET_VALUE <= REG_WDATA[7:0];
      end
    end
  end

  // ********************
  // Value decoding
  // ********************
  wire logic signed [17:0] cell_tenths = 18'(signed'({2'b00, MEAS.cell_temp_raw}))
    - 18'(arf_pkg::F_OFFSET);
  wire logic signed [17:0] board_whole = 18'(signed'({2'b00, MEAS.board_temp_raw}))
    - 18'(arf_pkg::K_OFFSET);
  wire logic signed [17:0] setpoint_whole = signed'({2'b00, MEAS.cell_setpoint_c});
  wire logic signed [21:0] cell_hundredths = 22'(cell_tenths) * 22'sd10;
  wire logic signed [21:0] setpoint_hundredths = 22'(setpoint_whole) * 22'sd100;
  wire logic signed [21:0] cell_error = cell_hundredths - setpoint_hundredths;
  wire logic cell_in_window = cell_error <= 22'(arf_pkg::CELL_WINDOW_HUNDREDTHS)
    && cell_error >= -22'(arf_pkg::CELL_WINDOW_HUNDREDTHS);

  // Both alarm setpoints and the reading share the offset format, so raw order is value order.
  wire logic o2_below_sp1 = MEAS.o2_raw < setpoint1_r;
  wire logic o2_above_sp1 = MEAS.o2_raw > setpoint1_r;
  wire logic o2_below_sp2 = MEAS.o2_raw < setpoint2_r;
  wire logic o2_above_sp2 = MEAS.o2_raw > setpoint2_r;
  wire logic [1:0] first_alarm_type = alarm_cfg_r[1:0];
  wire logic [1:0] second_alarm_type = alarm_cfg_r[3:2];
  wire logic low_alarm = (first_alarm_type == arf_pkg::ALARM_LOW && o2_below_sp1)
    || (second_alarm_type == arf_pkg::ALARM_LOW && o2_below_sp2);
  wire logic high_alarm = (first_alarm_type == arf_pkg::ALARM_HIGH && o2_above_sp1)
    || (second_alarm_type == arf_pkg::ALARM_HIGH && o2_above_sp2);

  // ********************
  // Cell temperature stability timer
  // ********************
  logic [31:0] tick_cnt_r;
  logic tick_r;
  logic [31:0] stable_cnt_r;
  wire logic cell_settled = stable_cnt_r >= 32'(STABLE_TICKS);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      stable_cnt_r <= 32'h0000_0000;
    end else if (!cell_in_window) begin
      stable_cnt_r <= 32'h0000_0000;
    end else if (tick_r && !cell_settled) begin
      stable_cnt_r <= stable_cnt_r + 32'h0000_0001;
    end
  end

  // ********************
  // Status word
  // ********************
  always_comb begin
    status_nxt = 16'h0000;
    status_nxt[0] = settings_r[4];
    status_nxt[1] = MEAS.out_of_range;
    status_nxt[2] = low_alarm;
    status_nxt[3] = high_alarm;
    status_nxt[4] = MEAS.comp_loop_ua < 16'(arf_pkg::LOOP_MIN_UA)
      || MEAS.comp_loop_ua > 16'(arf_pkg::LOOP_MAX_UA);
    status_nxt[5] = MEAS.ext_loop_ua < 16'(arf_pkg::LOOP_MIN_UA)
      || MEAS.ext_loop_ua > 16'(arf_pkg::LOOP_MAX_UA);
    status_nxt[6] = !cell_settled;
    status_nxt[7] = cell_tenths < 18'(arf_pkg::CELL_MIN_TENTHS)
      || cell_tenths > 18'(arf_pkg::CELL_MAX_TENTHS);
    status_nxt[8] = MEAS.pressure_mbar < 16'(arf_pkg::PRESS_MIN_MBAR)
      || MEAS.pressure_mbar > 16'(arf_pkg::PRESS_MAX_MBAR);
    status_nxt[9] = MEAS.o2_code <= arf_pkg::O2_CODE_LOW
      || MEAS.o2_code >= arf_pkg::O2_CODE_HIGH;
    status_nxt[10] = board_whole > setpoint_whole;
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      status_r <= 16'h0000;
    end else begin
      status_r <= status_nxt & arf_pkg::STATUS_MASK;
    end
  end

  // ********************
  // Indicators
  // ********************
  logic [31:0] flash_cnt_r;
  logic flash_phase_r;
  wire logic prio1_fault = |status_r[10:6];
  wire logic prio2_fault = |status_r[5:4];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      flash_cnt_r <= 32'h0000_0000;
      flash_phase_r <= 1'b0;
    end else if (tick_r) begin
      if (flash_cnt_r == 32'(FLASH_TICKS - 1)) begin
        flash_cnt_r <= 32'h0000_0000;
        flash_phase_r <= !flash_phase_r;
      end else begin
        flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      INDICATORS <= '0;
    end else begin
      INDICATORS.red_steady <= prio1_fault;
      INDICATORS.red_flash <= !prio1_fault && prio2_fault && flash_phase_r;
      INDICATORS.yellow1 <= status_r[2];
      INDICATORS.yellow2 <= status_r[3];
      INDICATORS.error_level_high <= alarm_cfg_r[4];
    end
  end

  // ********************
  // External sensor scaling
  // ********************
  logic [15:0] scale_zero;
  logic [15:0] scale_span;
  wire logic [1:0] ext_temp_unit = units_r[1:0];
  wire logic [1:0] ext_press_unit = units_r[3:2];

  always_comb begin
    scale_zero = arf_pkg::PRS_ZERO;
    scale_span = arf_pkg::PRS_ZERO;
    unique case (units_r[13:11])
      arf_pkg::EXT_DEWPOINT: begin
        unique case (ext_temp_unit)
          2'h1: begin
            scale_zero = arf_pkg::DEW_F_LO;
            scale_span = arf_pkg::DEW_F_HI;
          end
          2'h2: begin
            scale_zero = arf_pkg::DEW_K_LO;
            scale_span = arf_pkg::DEW_K_HI;
          end
          default: begin
            scale_zero = arf_pkg::DEW_C_LO;
            scale_span = arf_pkg::DEW_C_HI;
          end
        endcase
      end
      arf_pkg::EXT_TEMPERATURE: begin
        unique case (ext_temp_unit)
          2'h1: begin
            scale_zero = arf_pkg::TMP_F_LO;
            scale_span = arf_pkg::TMP_F_HI;
          end
          2'h2: begin
            scale_zero = arf_pkg::TMP_K_LO;
            scale_span = arf_pkg::TMP_K_HI;
          end
          default: begin
            scale_zero = arf_pkg::TMP_C_LO;
            scale_span = arf_pkg::TMP_C_HI;
          end
        endcase
      end
      arf_pkg::EXT_PRESSURE: begin
        scale_zero = arf_pkg::PRS_ZERO;
        unique case (ext_press_unit)
          2'h1: scale_span = arf_pkg::PRS_BAR_HI;
          2'h2: scale_span = arf_pkg::PRS_KPA_HI;
          default: scale_span = arf_pkg::PRS_PSIA_HI;
        endcase
      end
      default: begin
        scale_zero = arf_pkg::PRS_ZERO;
        scale_span = arf_pkg::PRS_ZERO;
      end
    endcase
  end

  // ********************
  // Configuration outputs
  // ********************
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      FEATURE_EN <= 6'h00;
      BRIGHTNESS <= 8'h00;
      CONTRAST <= 8'h00;
      TEMP_UNIT <= 2'h0;
      PRESS_UNIT <= 2'h0;
      TWO_GAS_CAL <= 1'b0;
      US_DATE <= 1'b0;
      EXT_QUANTITY <= 3'h0;
      EXT_SCALE_ZERO <= 16'h0000;
      EXT_SCALE_SPAN <= 16'h0000;
      STATUS <= 16'h0000;
    end else begin
      FEATURE_EN <= settings_r[5:0];
      BRIGHTNESS <= display_r[15:8];
      CONTRAST <= display_r[7:0];
      TEMP_UNIT <= units_r[1:0];
      PRESS_UNIT <= units_r[3:2];
      TWO_GAS_CAL <= units_r[4];
      US_DATE <= units_r[5];
      EXT_QUANTITY <= units_r[13:11];
      EXT_SCALE_ZERO <= scale_zero;
      EXT_SCALE_SPAN <= scale_span;
      STATUS <= status_r;
    end
  end

  // ********************
  // Read path
  // ********************
  logic [15:0] rd_mux;

  always_comb begin
    unique case (REG_ADDR)
      arf_pkg::OFS_FEATURE_SETTINGS: rd_mux = settings_r;
      arf_pkg::OFS_DISPLAY_PARAMETERS: rd_mux = display_r;
      arf_pkg::OFS_UNIT_SELECTION: rd_mux = units_r;
      arf_pkg::OFS_FIRST_ALARM_SETPOINT: rd_mux = setpoint1_r;
      arf_pkg::OFS_SECOND_ALARM_SETPOINT: rd_mux = setpoint2_r;
      arf_pkg::OFS_ALARM_ERROR_CONFIG: rd_mux = alarm_cfg_r;
      arf_pkg::OFS_STATUS_ERROR_FLAGS: rd_mux = status_r;
      arf_pkg::OFS_CLOCK_HOUR_MIN: rd_mux = {RTC.hours, RTC.minutes};
      arf_pkg::OFS_CLOCK_SEC_DAY: rd_mux = {RTC.seconds, RTC.day};
      arf_pkg::OFS_CLOCK_MONTH_YEAR: rd_mux = {RTC.month, RTC.year};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rd_mux;
      end
    end
  end

endmodule

/* File: tb/arf_register_bank_chk.sv */
// Checker of port relations for the analyzer register bank.
module arf_chk (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic REG_RVALID,
  // Inputs and results
  input wire arf_pkg::arf_meas_s MEAS,
  input wire arf_pkg::arf_rtc_s RTC,
  input wire logic RTC_SET,
  input wire logic [7:0] RTC_SET_VALUE,
  input wire logic [5:0] FEATURE_EN,
  input wire logic [15:0] STATUS,
  input wire arf_pkg::arf_ind_s INDICATORS
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  wire logic prs_bad = MEAS.pressure_mbar < 16'h02BC || MEAS.pressure_mbar > 16'h0514;
  wire logic cell_bad = MEAS.cell_temp_raw < 16'h4C2C || MEAS.cell_temp_raw > 16'h5140;
  chk_read_answer: assert property (REG_RD |=> REG_RVALID)
    else $error("read strobe got no answer");
  chk_clock_pack: assert property (REG_RD && REG_ADDR == 8'h4E |=>
    REG_RDATA == {$past(RTC.hours), $past(RTC.minutes)}) else $error("clock read packing wrong");
  chk_rtc_low_byte: assert property (REG_WR && REG_ADDR >= 8'h41 && REG_ADDR <= 8'h45 |=>
    RTC_SET && RTC_SET_VALUE == $past(REG_WDATA[7:0])) else $error("clock set wrong");
  chk_feature_follow: assert property (REG_WR && REG_ADDR == 8'h01 |->
    ##2 FEATURE_EN == $past(REG_WDATA[5:0], 2)) else $error("enables do not follow write");
  chk_status_read: assert property (REG_RD && REG_ADDR == 8'h4D |=> REG_RDATA == STATUS)
    else $error("status read differs");
  chk_status_unused: assert property (STATUS[15:11] == 5'h00)
    else $error("unused status bits set");
  chk_press_fault: assert property (!$past(RST) && !$past(RST, 2) |->
    STATUS[8] == $past(prs_bad, 2)) else $error("pressure fault flag wrong");
  chk_cell_fault: assert property (!$past(RST) && !$past(RST, 2) |->
    STATUS[7] == $past(cell_bad, 2)) else $error("cell sensor fault flag wrong");
  chk_red_priority: assert property (INDICATORS.red_steady |-> !INDICATORS.red_flash)
    else $error("flash shown under steady red");
  chk_red_steady: assert property (INDICATORS.red_steady == (|STATUS[10:6]))
    else $error("steady red differs from faults");
  chk_yellow_alarm: assert property ({INDICATORS.yellow2, INDICATORS.yellow1} == STATUS[3:2])
    else $error("yellow lamps differ from alarms");
endmodule
bind arf_register_bank arf_chk u_arf_chk (.CLOCK(CLOCK), .RST(RST), .REG_ADDR(REG_ADDR),
  .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .REG_RVALID(REG_RVALID), .MEAS(MEAS), .RTC(RTC), .RTC_SET(RTC_SET),
  .RTC_SET_VALUE(RTC_SET_VALUE), .FEATURE_EN(FEATURE_EN), .STATUS(STATUS),
  .INDICATORS(INDICATORS));

/* File: tb/arf_host.sv */
// Bus master model issuing one-cycle register strobes.
module arf_host (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] addr,
  output logic wr,
  output logic [15:0] wdata,
  output logic rd,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 8'h00;
    wr = 1'b0;
    wdata = 16'h0000;
    rd = 1'b0;
  end
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    ok = rvalid;
    d = rdata;
  endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the analyzer register bank.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLOCK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] addr, set_value, bright, contr;
  logic wr, rd, rvalid, rtc_set, two_gas, us_date;
  logic [15:0] wdata, rdata, zero, span, status, w, e;
  logic [2:0] set_field, ext_q;
  logic [5:0] feat;
  logic [1:0] t_unit, p_unit;
  arf_pkg::arf_meas_s meas = '0;
  arf_pkg::arf_rtc_s rtc = '0;
  arf_pkg::arf_ind_s ind;
  logic [31:0] seed = 32'h0000_0035;
  int n_mismatch = 0;
  int n_checks = 0;
  int x;
  int mdl[int];
  int ra[3] = '{1, 3, 22};
  logic [15:0] mk[3] = '{arf_pkg::SETTINGS_MASK, arf_pkg::UNITS_MASK, arf_pkg::ALARM_CFG_MASK};
  int sc[9][4] = '{'{1, 0, -1000, 200}, '{1, 1, -1480, 680}, '{1, 2, 1730, 2930},
    '{2, 0, -500, 1000}, '{2, 1, -580, 2120}, '{2, 2, 2230, 3730}, '{3, 0, 0, 441},
    '{3, 1, 0, 30}, '{3, 2, 0, 3040}};
  arf_register_bank #(.TICK_CYCLES(4), .STABLE_TICKS(10), .FLASH_TICKS(2)) u_arf_register_bank (
    .CLOCK(CLOCK), .RST(RST), .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wdata), .REG_RD(rd),
    .REG_RDATA(rdata), .REG_RVALID(rvalid), .MEAS(meas), .RTC(rtc), .RTC_SET(rtc_set),
    .RTC_SET_FIELD(set_field), .RTC_SET_VALUE(set_value), .FEATURE_EN(feat), .BRIGHTNESS(bright),
    .CONTRAST(contr), .TEMP_UNIT(t_unit), .PRESS_UNIT(p_unit), .TWO_GAS_CAL(two_gas),
    .US_DATE(us_date), .EXT_QUANTITY(ext_q), .EXT_SCALE_ZERO(zero), .EXT_SCALE_SPAN(span),
    .STATUS(status), .INDICATORS(ind));
  arf_host u_arf_host (.clk(CLOCK), .addr(addr), .wr(wr), .wdata(wdata), .rd(rd),
    .rdata(rdata), .rvalid(rvalid));
  initial forever #10 CLOCK = ~CLOCK;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Status word expected from the inputs, bit 6 left out.
  function automatic logic [15:0] st_exp();
    logic [15:0] s, c;
    int a6, a7;
    s = 16'h0000;
    c = 16'(mdl[22]);
    a6 = mdl[6];
    a7 = mdl[7];
    s[0] = mdl[1] % 32 >= 16;
    s[1] = meas.out_of_range;
    s[2] = (c[1:0] == 2'h1 && meas.o2_raw < a6) || (c[3:2] == 2'h1 && meas.o2_raw < a7);
    s[3] = (c[1:0] == 2'h2 && meas.o2_raw > a6) || (c[3:2] == 2'h2 && meas.o2_raw > a7);
    s[4] = meas.comp_loop_ua < arf_pkg::LOOP_MIN_UA || meas.comp_loop_ua > arf_pkg::LOOP_MAX_UA;
    s[5] = meas.ext_loop_ua < arf_pkg::LOOP_MIN_UA || meas.ext_loop_ua > arf_pkg::LOOP_MAX_UA;
    s[7] = meas.cell_temp_raw < arf_pkg::F_OFFSET + arf_pkg::CELL_MIN_TENTHS ||
      meas.cell_temp_raw > arf_pkg::F_OFFSET + arf_pkg::CELL_MAX_TENTHS;
    s[8] = meas.pressure_mbar < arf_pkg::PRESS_MIN_MBAR || meas.pressure_mbar > arf_pkg::PRESS_MAX_MBAR;
    s[9] = meas.o2_code <= arf_pkg::O2_CODE_LOW || meas.o2_code >= arf_pkg::O2_CODE_HIGH;
    s[10] = int'(meas.board_temp_raw) - arf_pkg::K_OFFSET > int'(meas.cell_setpoint_c);
    return s;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] ex, input string what);
    logic [15:0] d;
    logic ok;
    u_arf_host.rd_reg(a, d, ok);
    chk({15'h0000, ok}, 16'h0001, "read valid");
    chk(d, ex, what);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #600000;
    n_mismatch++;
    final_report();
  end
  initial begin
    mdl[1] = 0;
    mdl[2] = 12850;
    mdl[3] = 0;
    mdl[22] = 0;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    foreach (ra[i]) rdchk(8'(ra[i]), 16'(mdl[ra[i]]), "reset value");
    rdchk(8'h02, 16'(mdl[2]), "display reset");
    $display("test reset done");
    foreach (ra[i]) begin
      for (int k = 0; k < 4; k++) begin
        w = 16'(rnd());
        mdl[ra[i]] = w & mk[i];
        u_arf_host.wr_reg(8'(ra[i]), w);
        rdchk(8'(ra[i]), 16'(mdl[ra[i]]), "masked word");
      end
    end
    chk({10'h000, feat}, 16'(mdl[1]), "enables");
    chk({2'h0, ext_q, 5'h00, us_date, two_gas, p_unit, t_unit}, 16'(mdl[3]), "units");
    chk({15'h0000, ind.error_level_high}, 16'(mdl[22] / 16 % 2), "error level");
    $display("test masked words done");
    for (int v = 0; v < 12; v++) begin
      w = {8'(v * 10), 8'(v * 10 + 3 * (v % 2))};
      e = 16'(mdl[2]);
      if (w[15:8] <= arf_pkg::PERCENT_MAX) e[15:8] = w[15:8];
      if (w[7:0] <= arf_pkg::PERCENT_MAX && w[7:0] % 10 == 0) e[7:0] = w[7:0];
      mdl[2] = e;
      u_arf_host.wr_reg(8'h02, w);
      rdchk(8'h02, e, "display");
    end
    chk({bright, contr}, 16'(mdl[2]), "display bytes");
    u_arf_host.wr_reg(8'h00, 16'hFFFF);
    u_arf_host.wr_reg(8'h4D, 16'hFFFF);
    rdchk(8'h01, 16'(mdl[1]), "stray write");
    $display("test display done");
    @(posedge CLOCK);
    rtc <= 48'({rnd(), rnd()});
    #1;
    rdchk(8'h4E, {rtc.hours, rtc.minutes}, "clock hm");
    rdchk(8'h4F, {rtc.seconds, rtc.day}, "clock sd");
    rdchk(8'h50, {rtc.month, rtc.year}, "clock my");
    for (int f = 0; f < 5; f++) begin
      w = 16'(rnd());
      u_arf_host.wr_reg(8'(65 + f), w);
      #1;
      chk({rtc_set, 4'h0, set_field, set_value}, {1'b1, 4'h0, 3'(f), w[7:0]}, "clock set");
    end
    $display("test clock done");
    mdl[6] = 20500;
    mdl[7] = 20800;
    mdl[22] = 9;
    mdl[1] = 16;
    u_arf_host.wr_reg(8'h06, 16'h5014);
    u_arf_host.wr_reg(8'h07, 16'h5140);
    u_arf_host.wr_reg(8'h16, 16'h0009);
    u_arf_host.wr_reg(8'h01, 16'h0010);
    @(posedge CLOCK);
    meas <= '{1'b0, 16'h4E20, 16'h2EE0, 16'h2EE0, 16'h5014, 16'h0032, 16'h03E8, 13'h0800, 16'h801D};
    repeat (60) @(posedge CLOCK);
    #1;
    chk(status, st_exp(), "cell settled");
    rdchk(8'h4D, st_exp(), "status read");
    @(posedge CLOCK);
    meas.cell_temp_raw <= 16'h5016;
    repeat (3) @(posedge CLOCK);
    #1;
    chk(status, st_exp() | 16'h0040, "cell unsettled");
    for (int i = 0; i < 24; i++) begin
      x = rnd() % 4;
      @(posedge CLOCK);
      meas <= '{1'(rnd()), 16'(19000 + rnd() % 3000), 16'(3000 + rnd() % 19000),
        16'(3000 + rnd() % 19000), 16'(19400 + rnd() % 1500), 16'(40 + rnd() % 30),
        16'(600 + rnd() % 800), 13'(x == 0 ? 1 : x == 1 ? 8191 : rnd()), 16'(32800 + rnd() % 80)};
      repeat (3) @(posedge CLOCK);
      #1;
      chk(status & 16'hFFBF, st_exp(), "status flags");
    end
    $display("test status done");
    foreach (sc[i]) begin
      w = 16'(sc[i][0] * 2048 + sc[i][1] * (sc[i][0] == 3 ? 4 : 1));
      u_arf_host.wr_reg(8'h03, w);
      repeat (3) @(posedge CLOCK);
      #1;
      chk(zero, 16'(arf_pkg::F_OFFSET + sc[i][2]), "scale zero");
      chk(span, 16'(arf_pkg::F_OFFSET + sc[i][3]), "scale span");
    end
    $display("test scaling done");
    final_report();
  end
endmodule
